// ===== rx_packet_status_counters.sv
// Purpose: receive packet status, latched events, interrupt and packet counters
// Assumes: packet processor signals and processor port are on sys_clk
// Notes: latched status is write-one-to-clear; counters read their last snapshot
//
// Contract
// - size nonzero bit follows size count, read-only
// - bad FCS packet latches crc event bit
// - aborted packet latches abort event bit
// - non-whole-byte packet latches fractional event bit
// - short packet latches undersize event bit
// - long packet latches oversize event bit
// - count-nonzero latches set on rising edge only
// - enable bit per latched bit gates interrupt
// - 24-bit good packet count, three byte registers
// - discarded loopback or overflow packets still counted
// - good count counts chunks in clear channel
// - 24-bit FCS error packet count, three bytes
// - 24-bit aborted packet count, three bytes
// - errored and aborted bytes go to aborted bytes
// - low address low byte, high address high byte
// - trigger rising edge snapshots and restarts counters

`timescale 1ns/1ns

module rx_packet_status_counters (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [rx_stat_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [rx_stat_pkg::DATA_W-1:0] cpu_wdata,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   output logic [rx_stat_pkg::DATA_W-1:0] cpu_rdata,
   input wire logic pkt_end,
   input wire logic pkt_abort,
   input wire logic pkt_crc_bad,
   input wire logic pkt_fractional,
   input wire logic pkt_undersize,
   input wire logic pkt_oversize,
   input wire logic pkt_discarded,
   input wire logic clear_channel_mode,
   input wire logic [rx_stat_pkg::LEN_W-1:0] pkt_len_bytes,
   output logic good_bytes_add,
   output logic aborted_bytes_add,
   output logic [rx_stat_pkg::LEN_W-1:0] bytes_add_len,
   output logic irq
);
   import rx_stat_pkg::*;

   // ***************************************************
   // declarations
   // ***************************************************
   logic [EVT_W-1:0] latched_status;
   logic [EVT_W-1:0] irq_enable;
   logic [EVT_W-1:0] set_bits;
   logic [EVT_W-1:0] clear_bits;
   logic [CNT_W-1:0] good_count;
   logic [CNT_W-1:0] crc_count;
   logic [CNT_W-1:0] abort_count;
   logic [CNT_W-1:0] size_count;
   logic snap_trigger;
   logic snap_trigger_prev;
   logic snap_pulse;
   logic snap_done;
   logic crc_count_nonzero;
   logic abort_count_nonzero;
   logic size_violation_count_nonzero;
   logic crc_nz_prev;
   logic abort_nz_prev;
   logic size_nz_prev;
   logic framed_end;
   logic size_any;
   logic is_abort;
   logic is_crc;
   logic is_size;
   logic is_good;
   logic good_inc;
   logic crc_inc;
   logic abort_inc;
   logic size_inc;
   logic [DATA_W-1:0] rx_live_status;
   logic [DATA_W-1:0] next_rdata;

   // ***************************************************
   // packet classification
   // ***************************************************
   // in clear channel mode no error checks run, every chunk is good
   assign framed_end = pkt_end & ~clear_channel_mode;
   assign size_any = pkt_fractional | pkt_undersize | pkt_oversize;

   // abort outranks FCS, FCS outranks size, so each packet lands in one count
   assign is_abort = framed_end & pkt_abort;
   assign is_crc = framed_end & ~pkt_abort & pkt_crc_bad;
   assign is_size = framed_end & ~pkt_abort & ~pkt_crc_bad & size_any;

   // discard after storage does not stop counting, pkt_discarded is ignored
   assign is_good = pkt_end & (clear_channel_mode | ~(pkt_abort | pkt_crc_bad | size_any));

   assign good_inc = is_good;
   assign crc_inc = is_crc;
   assign abort_inc = is_abort;
   assign size_inc = is_size;

   // ***************************************************
   // byte count steering
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         good_bytes_add <= 1'b0;
         aborted_bytes_add <= 1'b0;
         bytes_add_len <= RESET_LEN;
      end else begin
         good_bytes_add <= is_good;
         aborted_bytes_add <= is_abort | is_crc | is_size;
         bytes_add_len <= pkt_len_bytes;
      end
   end

   // ***************************************************
   // snapshot trigger
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         snap_trigger <= 1'b0;
      end else if (cpu_wr && cpu_addr == ADDR_SNAP_TRIGGER) begin
         snap_trigger <= cpu_wdata[BIT_SNAP];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         snap_trigger_prev <= 1'b0;
      end else begin
         snap_trigger_prev <= snap_trigger;
      end
   end

   // only the 0-to-1 edge copies; holding the bit high does nothing more
   assign snap_pulse = snap_trigger & ~snap_trigger_prev;

   // done follows the copy and drops when software returns the trigger to 0
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         snap_done <= 1'b0;
      end else if (!snap_trigger) begin
         snap_done <= 1'b0;
      end else if (snap_pulse) begin
         snap_done <= 1'b1;
      end
   end

   // ***************************************************
   // packet counters
   // ***************************************************
   snapshot_counter good_counter (
      .sys_clk(sys_clk),
      .reset(reset),
      .count_en(good_inc),
      .snap(snap_pulse),
      .held(good_count)
   );

   snapshot_counter crc_error_counter (
      .sys_clk(sys_clk),
      .reset(reset),
      .count_en(crc_inc),
      .snap(snap_pulse),
      .held(crc_count)
   );

   snapshot_counter abort_counter (
      .sys_clk(sys_clk),
      .reset(reset),
      .count_en(abort_inc),
      .snap(snap_pulse),
      .held(abort_count)
   );

   // size count has no readable bytes here, it only drives the nonzero bit
   snapshot_counter size_counter (
      .sys_clk(sys_clk),
      .reset(reset),
      .count_en(size_inc),
      .snap(snap_pulse),
      .held(size_count)
   );

   // ***************************************************
   // live status
   // ***************************************************
   // nonzero bits follow the readable counts, so they agree with what is read
   assign crc_count_nonzero = |crc_count;
   assign abort_count_nonzero = |abort_count;
   assign size_violation_count_nonzero = |size_count;

   always_comb begin
      rx_live_status = RESET_BYTE;
      rx_live_status[BIT_CRC_CNT] = crc_count_nonzero;
      rx_live_status[BIT_ABORT_CNT] = abort_count_nonzero;
      rx_live_status[BIT_SIZE_CNT] = size_violation_count_nonzero;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         crc_nz_prev <= 1'b0;
         abort_nz_prev <= 1'b0;
         size_nz_prev <= 1'b0;
      end else begin
         crc_nz_prev <= crc_count_nonzero;
         abort_nz_prev <= abort_count_nonzero;
         size_nz_prev <= size_violation_count_nonzero;
      end
   end

   // ***************************************************
   // latched status
   // ***************************************************
   always_comb begin
      set_bits = RESET_BYTE;
      set_bits[BIT_CRC_EVT] = framed_end & pkt_crc_bad;
      set_bits[BIT_ABORT_EVT] = framed_end & pkt_abort;
      set_bits[BIT_FRAC_EVT] = framed_end & pkt_fractional;
      set_bits[BIT_UNDER_EVT] = framed_end & pkt_undersize;
      set_bits[BIT_OVER_EVT] = framed_end & pkt_oversize;
      set_bits[BIT_CRC_CNT] = crc_count_nonzero & ~crc_nz_prev;
      set_bits[BIT_ABORT_CNT] = abort_count_nonzero & ~abort_nz_prev;
      set_bits[BIT_SIZE_CNT] = size_violation_count_nonzero & ~size_nz_prev;
   end

   always_comb begin
      clear_bits = RESET_BYTE;
      if (cpu_wr && cpu_addr == ADDR_LATCHED_STATUS) begin
         clear_bits = cpu_wdata;
      end
   end

   // write one clears; a set in the same cycle wins so no event is lost
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latched_status <= RESET_BYTE;
      end else begin
         latched_status <= (latched_status & ~clear_bits) | set_bits;
      end
   end

   // ***************************************************
   // interrupt enable and request
   // ***************************************************
   // software must hold the crc count enable low when frames carry no FCS
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_enable <= RESET_BYTE;
      end else if (cpu_wr && cpu_addr == ADDR_IRQ_ENABLE) begin
         irq_enable <= cpu_wdata;
      end
   end

   // registered so the pin is glitch free, at the cost of one cycle of lag
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(latched_status & irq_enable);
      end
   end

   // ***************************************************
   // read path
   // ***************************************************
   always_comb begin
      next_rdata = RESET_BYTE;
      case (cpu_addr)
         ADDR_LIVE_STATUS: begin
            next_rdata = rx_live_status;
         end
         ADDR_LATCHED_STATUS: begin
            next_rdata = latched_status;
         end
         ADDR_IRQ_ENABLE: begin
            next_rdata = irq_enable;
         end
         ADDR_GOOD_B0: begin
            next_rdata = good_count[BYTE0_LSB +: DATA_W];
         end
         ADDR_GOOD_B1: begin
            next_rdata = good_count[BYTE1_LSB +: DATA_W];
         end
         ADDR_GOOD_B2: begin
            next_rdata = good_count[BYTE2_LSB +: DATA_W];
         end
         ADDR_CRC_B0: begin
            next_rdata = crc_count[BYTE0_LSB +: DATA_W];
         end
         ADDR_CRC_B1: begin
            next_rdata = crc_count[BYTE1_LSB +: DATA_W];
         end
         ADDR_CRC_B2: begin
            next_rdata = crc_count[BYTE2_LSB +: DATA_W];
         end
         ADDR_ABORT_B0: begin
            next_rdata = abort_count[BYTE0_LSB +: DATA_W];
         end
         ADDR_ABORT_B1: begin
            next_rdata = abort_count[BYTE1_LSB +: DATA_W];
         end
         ADDR_ABORT_B2: begin
            next_rdata = abort_count[BYTE2_LSB +: DATA_W];
         end
         ADDR_SNAP_TRIGGER: begin
            next_rdata[BIT_SNAP] = snap_trigger;
         end
         ADDR_SNAP_STATUS: begin
            next_rdata[BIT_SNAP] = snap_done;
         end
         default: begin
            next_rdata = RESET_BYTE;
         end
      endcase
   end

   // data holds after a read until the next read strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cpu_rdata <= RESET_BYTE;
      end else if (cpu_rd) begin
         cpu_rdata <= next_rdata;
      end
   end

endmodule

// ===== rx_packet_status_counters_sva.sv
// Purpose: port-level checks for rx_packet_status_counters
// Assumes: one clock, synchronous active-high reset
// Notes: enable register is internal, so irq is judged against seen enable writes
`timescale 1ns/1ns
module rx_packet_status_counters_sva (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [rx_stat_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [rx_stat_pkg::DATA_W-1:0] cpu_wdata,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [rx_stat_pkg::DATA_W-1:0] cpu_rdata,
   input wire logic pkt_end,
   input wire logic pkt_abort,
   input wire logic pkt_crc_bad,
   input wire logic pkt_fractional,
   input wire logic pkt_undersize,
   input wire logic pkt_oversize,
   input wire logic pkt_discarded,
   input wire logic clear_channel_mode,
   input wire logic [rx_stat_pkg::LEN_W-1:0] pkt_len_bytes,
   input wire logic good_bytes_add,
   input wire logic aborted_bytes_add,
   input wire logic [rx_stat_pkg::LEN_W-1:0] bytes_add_len,
   input wire logic irq
);
   import rx_stat_pkg::*;
   logic [DATA_W-1:0] en_shadow;
   logic flagged;
   assign flagged = pkt_abort | pkt_crc_bad | pkt_fractional | pkt_undersize | pkt_oversize;
   // shadow of the enable register, so a later zero write is tracked too
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         en_shadow <= RESET_BYTE;
      end else if (cpu_wr && cpu_addr == ADDR_IRQ_ENABLE) begin
         en_shadow <= cpu_wdata;
      end
   end
   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ****************
   // properties
   // ****************
   property p_abort_steer;
      pkt_end && pkt_abort && !clear_channel_mode |=> aborted_bytes_add && !good_bytes_add;
   endproperty
   a_abort_steer: assert property (p_abort_steer) else $error("abort bytes misrouted");
   property p_crc_steer;
      pkt_end && pkt_crc_bad && !clear_channel_mode |=> aborted_bytes_add && !good_bytes_add;
   endproperty
   a_crc_steer: assert property (p_crc_steer) else $error("fcs bytes misrouted");
   property p_good_steer;
      pkt_end && (!flagged || clear_channel_mode) |=> good_bytes_add && !aborted_bytes_add;
   endproperty
   a_good_steer: assert property (p_good_steer) else $error("good bytes misrouted");
   property p_len_copy;
      pkt_end |=> bytes_add_len == $past(pkt_len_bytes);
   endproperty
   a_len_copy: assert property (p_len_copy) else $error("byte length not passed");
   property p_pulse_only;
      !pkt_end |=> !good_bytes_add && !aborted_bytes_add;
   endproperty
   a_pulse_only: assert property (p_pulse_only) else $error("byte add without packet");
   property p_irq_needs_en;
      en_shadow == RESET_BYTE |=> !irq;
   endproperty
   a_irq_needs_en: assert property (p_irq_needs_en) else $error("irq with no enable");
   property p_abort_latch;
      pkt_end && pkt_abort && !clear_channel_mode ##1 !cpu_wr
         ##1 cpu_rd && cpu_addr == ADDR_LATCHED_STATUS |=> cpu_rdata[BIT_ABORT_EVT];
   endproperty
   a_abort_latch: assert property (p_abort_latch) else $error("abort not latched");
   property p_unmapped;
      cpu_rd && cpu_addr == 10'h107 |=> cpu_rdata == RESET_BYTE;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind rx_packet_status_counters rx_packet_status_counters_sva chk_u (
   .sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
   .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .pkt_end(pkt_end),
   .pkt_abort(pkt_abort), .pkt_crc_bad(pkt_crc_bad), .pkt_fractional(pkt_fractional),
   .pkt_undersize(pkt_undersize), .pkt_oversize(pkt_oversize), .pkt_discarded(pkt_discarded),
   .clear_channel_mode(clear_channel_mode), .pkt_len_bytes(pkt_len_bytes),
   .good_bytes_add(good_bytes_add), .aborted_bytes_add(aborted_bytes_add),
   .bytes_add_len(bytes_add_len), .irq(irq)
);

// ===== rx_packet_status_counters_tb.sv
// Purpose: directed register-level test of rx_packet_status_counters
// Assumes: strobe port as handed over, counters read their last snapshot
// Notes: the long burst makes all three count bytes differ
`timescale 1ns/1ns
module rx_packet_status_counters_tb;
   import rx_stat_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] cpu_addr = 10'h000;
   logic [DATA_W-1:0] cpu_wdata = 8'h00;
   logic cpu_wr = 1'b0;
   logic cpu_rd = 1'b0;
   logic [DATA_W-1:0] cpu_rdata;
   logic pkt_end = 1'b0;
   logic [4:0] flags = 5'h00; // crc, abort, fractional, under, over
   logic pkt_discarded = 1'b0;
   logic clear_channel_mode = 1'b0;
   logic [LEN_W-1:0] pkt_len_bytes = 16'h0000;
   logic good_bytes_add;
   logic aborted_bytes_add;
   logic [LEN_W-1:0] bytes_add_len;
   logic irq;
   int err_total = 0;
   int checks_done = 0;
   logic [ADDR_W-1:0] zero_list [13] = '{ADDR_LIVE_STATUS, ADDR_LATCHED_STATUS,
      ADDR_IRQ_ENABLE, ADDR_GOOD_B0, ADDR_GOOD_B1, ADDR_GOOD_B2, ADDR_CRC_B0, ADDR_CRC_B1,
      ADDR_CRC_B2, ADDR_ABORT_B0, ADDR_ABORT_B1, ADDR_ABORT_B2, 10'h107};
   always #10 sys_clk = ~sys_clk;
   rx_packet_status_counters dut_u (
      .sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .pkt_end(pkt_end),
      .pkt_crc_bad(flags[4]), .pkt_abort(flags[3]), .pkt_fractional(flags[2]),
      .pkt_undersize(flags[1]), .pkt_oversize(flags[0]), .pkt_discarded(pkt_discarded),
      .clear_channel_mode(clear_channel_mode), .pkt_len_bytes(pkt_len_bytes),
      .good_bytes_add(good_bytes_add), .aborted_bytes_add(aborted_bytes_add),
      .bytes_add_len(bytes_add_len), .irq(irq)
   );
   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge sys_clk);
      cpu_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge sys_clk);
      cpu_rd <= 1'b0;
      #1;
      chk({16'h0000, cpu_rdata}, {16'h0000, exp});
   endtask
   task automatic cnt_chk(input logic [ADDR_W-1:0] b0, input logic [CNT_W-1:0] e);
      rd_chk(b0, e[7:0]);
      rd_chk(b0 + 10'h001, e[15:8]);
      rd_chk(b0 + 10'h002, e[23:16]);
   endtask
   task automatic pkt(input logic [4:0] f, input logic ccm, input logic disc,
      input logic [LEN_W-1:0] len);
      logic bad;
      bad = !ccm && (f != 5'h00);
      @(posedge sys_clk);
      pkt_end <= 1'b1;
      flags <= f;
      clear_channel_mode <= ccm;
      pkt_discarded <= disc;
      pkt_len_bytes <= len;
      @(posedge sys_clk);
      pkt_end <= 1'b0;
      flags <= 5'h00;
      clear_channel_mode <= 1'b0;
      pkt_discarded <= 1'b0;
      #1;
      chk({22'h0, good_bytes_add, aborted_bytes_add}, {22'h0, !bad, bad});
      chk({8'h00, bytes_add_len}, {8'h00, len});
   endtask
   // trigger must drop before rising again, so each snapshot writes 0 first
   task automatic snap();
      wr(ADDR_SNAP_TRIGGER, 8'h00);
      rd_chk(ADDR_SNAP_STATUS, 8'h00);
      wr(ADDR_SNAP_TRIGGER, 8'h01);
      repeat (3) @(posedge sys_clk);
      rd_chk(ADDR_SNAP_STATUS, 8'h01);
   endtask
   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge sys_clk);
      err_total++;
      give_verdict();
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      wr(ADDR_GOOD_B0, 8'hff);
      wr(ADDR_LIVE_STATUS, 8'h07);
      wr(10'h107, 8'hff);
      foreach (zero_list[i]) rd_chk(zero_list[i], 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'ha3); // crc count enable left low
      rd_chk(ADDR_IRQ_ENABLE, 8'ha3);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      for (int k = 0; k < 5; k++) begin
         logic [DATA_W-1:0] m;
         m = 8'h08 << k;
         pkt(5'h01 << k, 1'b0, 1'b0, 16'h0040);
         rd_chk(ADDR_LATCHED_STATUS, m);
         chk({23'h0, irq}, 24'h00_0000);
         wr(ADDR_IRQ_ENABLE, m);
         repeat (2) @(posedge sys_clk);
         #1;
         chk({23'h0, irq}, 24'h00_0001);
         wr(ADDR_LATCHED_STATUS, 8'hff);
         rd_chk(ADDR_LATCHED_STATUS, 8'h00);
         chk({23'h0, irq}, 24'h00_0000);
         wr(ADDR_IRQ_ENABLE, 8'h00);
      end
      pkt(5'h18, 1'b0, 1'b0, 16'h0100);
      rd_chk(ADDR_LATCHED_STATUS, 8'hc0);
      wr(ADDR_LATCHED_STATUS, 8'hff);
      pkt(5'h00, 1'b0, 1'b0, 16'h0020);
      pkt(5'h00, 1'b0, 1'b1, 16'h0021);
      pkt(5'h08, 1'b1, 1'b0, 16'h0022);
      rd_chk(ADDR_LATCHED_STATUS, 8'h00);
      rd_chk(ADDR_GOOD_B0, 8'h00);
      snap();
      wr(ADDR_SNAP_TRIGGER, 8'h01);
      cnt_chk(ADDR_GOOD_B0, 24'h00_0003);
      cnt_chk(ADDR_CRC_B0, 24'h00_0001);
      cnt_chk(ADDR_ABORT_B0, 24'h00_0002);
      rd_chk(ADDR_LIVE_STATUS, 8'h07);
      rd_chk(ADDR_LATCHED_STATUS, 8'h07);
      wr(ADDR_LATCHED_STATUS, 8'h07);
      snap();
      cnt_chk(ADDR_GOOD_B0, 24'h00_0000);
      rd_chk(ADDR_LIVE_STATUS, 8'h00);
      rd_chk(ADDR_LATCHED_STATUS, 8'h00);
      @(posedge sys_clk);
      pkt_end <= 1'b1;
      repeat (66051) @(posedge sys_clk);
      pkt_end <= 1'b0;
      pkt(5'h10, 1'b0, 1'b0, 16'h0080);
      snap();
      cnt_chk(ADDR_GOOD_B0, 24'h01_0203);
      cnt_chk(ADDR_CRC_B0, 24'h00_0001);
      rd_chk(ADDR_LIVE_STATUS, 8'h04);
      rd_chk(ADDR_LATCHED_STATUS, 8'h84);
      give_verdict();
   end
endmodule

// ===== rx_stat_pkg.sv
// Purpose: shared constants for the receive packet status and counter block
// Assumes: byte-wide processor port, 10-bit register address
// Notes: offsets are byte addresses of the processor port

package rx_stat_pkg;

   // ***************************************************
   // widths
   // ***************************************************
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int CNT_W = 24;
   localparam int LEN_W = 16;
   localparam int EVT_W = 8;

   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [ADDR_W-1:0] ADDR_LIVE_STATUS = 10'h104;
   localparam logic [ADDR_W-1:0] ADDR_LATCHED_STATUS = 10'h105;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 10'h106;
   localparam logic [ADDR_W-1:0] ADDR_GOOD_B0 = 10'h108;
   localparam logic [ADDR_W-1:0] ADDR_GOOD_B1 = 10'h109;
   localparam logic [ADDR_W-1:0] ADDR_GOOD_B2 = 10'h10a;
   localparam logic [ADDR_W-1:0] ADDR_CRC_B0 = 10'h10c;
   localparam logic [ADDR_W-1:0] ADDR_CRC_B1 = 10'h10d;
   localparam logic [ADDR_W-1:0] ADDR_CRC_B2 = 10'h10e;
   localparam logic [ADDR_W-1:0] ADDR_ABORT_B0 = 10'h110;
   localparam logic [ADDR_W-1:0] ADDR_ABORT_B1 = 10'h111;
   localparam logic [ADDR_W-1:0] ADDR_ABORT_B2 = 10'h112;
   localparam logic [ADDR_W-1:0] ADDR_SNAP_TRIGGER = 10'h120;
   localparam logic [ADDR_W-1:0] ADDR_SNAP_STATUS = 10'h121;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int BIT_CRC_EVT = 7;
   localparam int BIT_ABORT_EVT = 6;
   localparam int BIT_FRAC_EVT = 5;
   localparam int BIT_UNDER_EVT = 4;
   localparam int BIT_OVER_EVT = 3;
   localparam int BIT_CRC_CNT = 2;
   localparam int BIT_ABORT_CNT = 1;
   localparam int BIT_SIZE_CNT = 0;
   localparam int BIT_SNAP = 0;
   localparam int BYTE0_LSB = 0;
   localparam int BYTE1_LSB = 8;
   localparam int BYTE2_LSB = 16;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [CNT_W-1:0] RESET_CNT = 24'h00_0000;
   localparam logic [LEN_W-1:0] RESET_LEN = 16'h0000;

endpackage

// ===== snapshot_counter.sv
// Purpose: 24-bit live counter with a held copy taken on a snapshot pulse
// Assumes: count_en and snap are one-cycle pulses on sys_clk
// Notes: an event in the snapshot cycle starts the new interval

`timescale 1ns/1ns

module snapshot_counter (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic count_en,
   input wire logic snap,
   output logic [rx_stat_pkg::CNT_W-1:0] held
);
   import rx_stat_pkg::*;

   logic [CNT_W-1:0] live;

   // ***************************************************
   // live count, restarted by the snapshot
   // ***************************************************
   // the event in the snapshot cycle is kept, never lost between intervals
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         live <= RESET_CNT;
      end else if (snap) begin
         live <= CNT_W'(count_en);
      end else if (count_en) begin
         live <= live + CNT_W'(1);
      end
   end

   // ***************************************************
   // readable copy
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         held <= RESET_CNT;
      end else if (snap) begin
         held <= live;
      end
   end

endmodule
